// [hdl/rlc_pkg.sv]
// Constants and types shared by the right limiter and DAC clip register bank.
package rlc_pkg;

    // Register indices as printed; the APB byte address is four times the index.
    localparam logic [7:0] RLC_THR_SLOPE_IDX = 8'h12;
    localparam logic [7:0] RLC_KNEE_IDX = 8'h13;
    localparam logic [7:0] RLC_CLIP_L_IDX = 8'h14;
    localparam logic [7:0] RLC_CLIP_R_IDX = 8'h15;
    localparam logic [7:0] RLC_CTRL_IDX = 8'h18;
    localparam logic [7:0] RLC_STAT_IDX = 8'h19;
    localparam int RLC_ADDR_W = 10;

    // Field positions of the threshold and slope register.
    localparam int RLC_THR_MSB = 7;
    localparam int RLC_THR_LSB = 3;
    localparam int RLC_SLOPE_MSB = 1;
    localparam int RLC_SLOPE_LSB = 0;

    // Field positions of the control register.
    localparam int RLC_CTRL_LINK_BIT = 3;
    localparam int RLC_CTRL_TRACK_BIT = 2;
    localparam int RLC_CTRL_MODE_MSB = 1;

    // Field positions of the status register.
    localparam int RLC_STAT_BELOW_BIT = 0;
    localparam int RLC_STAT_ACTIVE_BIT = 1;
    localparam int RLC_STAT_MUTE_BIT = 2;
    localparam int RLC_STAT_THR_LSB = 3;

    // Reset values.
    localparam logic [7:0] RLC_THR_SLOPE_RST = 8'h51;
    localparam logic [7:0] RLC_KNEE_RST = 8'h22;
    localparam logic [7:0] RLC_CLIP_RST = 8'hff;
    localparam logic [7:0] RLC_CTRL_RST = 8'h08;

    // Deepest threshold code, 2 V peak.
    localparam logic [4:0] RLC_THR_MAX = 5'h1f;

    // Right limiter modes.
    typedef enum logic [1:0] {
        RLC_MODE_OFF = 2'h0,
        RLC_MODE_ON = 2'h1,
        RLC_MODE_MUTE_LOW = 2'h2,
        RLC_MODE_ON_LOW = 2'h3
    } rlc_mode_type;

endpackage : rlc_pkg

// [hdl/rlc_clip.sv]
// One DAC high-frequency clip level register and its level numerator.
`timescale 1ns/100ps
module rlc_clip
    import rlc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] clip_code,
    output logic [8:0] clip_level
);

    logic [7:0] code_r;
    logic [7:0] code_nxt;

    // The code holds unless the bus writes it.
    always_comb begin
        code_nxt = code_r;
        if (wr_en) begin
            code_nxt = wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_r <= RLC_CLIP_RST;
        end else begin
            code_r <= code_nxt;
        end
    end

    assign clip_code = code_r;
    // Never zero, so code 0 still passes 1/256 rather than muting.
    assign clip_level = {1'b0, code_r} + 9'h001;

    a_clip_nonzero: assert property (@(posedge pclk) disable iff (!presetn)
        clip_level != 9'h000)
        else $error("clip level reached zero");

    a_clip_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en |=> clip_level == {1'b0, $past(wr_data)} + 9'h001)
        else $error("clip level does not follow written code");

endmodule : rlc_clip

// [hdl/rlc_top.sv]
// APB register bank for the right limiter threshold, battery knee and DAC clip levels.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module rlc_top
    import rlc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [RLC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] battery_code,
    input wire logic [4:0] left_threshold_code,
    output logic [4:0] right_threshold_code,
    output logic right_limiter_active,
    output logic right_mute,
    output logic right_use_left_limiter,
    output logic [8:0] left_clip_level,
    output logic [8:0] right_clip_level
);

    // Register state and next values.
    logic [4:0] thr_r;
    logic [4:0] thr_nxt;
    logic [1:0] slope_r;
    logic [1:0] slope_nxt;
    logic [7:0] knee_r;
    logic [7:0] knee_nxt;
    logic [3:0] ctrl_r;
    logic [3:0] ctrl_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic hit_r;
    logic hit_nxt;

    // Datapath state and next values.
    logic [4:0] eff_thr_r;
    logic [4:0] eff_thr_nxt;
    logic active_r;
    logic active_nxt;
    logic mute_r;
    logic mute_nxt;
    logic below_r;
    logic below_nxt;

    // Bus decode.
    logic [7:0] idx;
    logic addr_ok;
    logic setup;
    logic wr_go;
    logic lane0;
    logic [7:0] wbyte;
    logic [7:0] clip_l_code;
    logic [7:0] clip_r_code;
    logic wr_clip_l;
    logic wr_clip_r;
    rlc_mode_type mode;

    // Tracking arithmetic.
    logic [7:0] deficit;
    logic [9:0] reduction;
    logic [10:0] deeper;

    // Only word-aligned addresses in the map answer without an error.
    assign idx = paddr[RLC_ADDR_W-1:2];
    assign addr_ok = (paddr[1:0] == 2'h0) &&
        ((idx == RLC_THR_SLOPE_IDX) || (idx == RLC_KNEE_IDX) ||
         (idx == RLC_CLIP_L_IDX) || (idx == RLC_CLIP_R_IDX) ||
         (idx == RLC_CTRL_IDX) || (idx == RLC_STAT_IDX));
    assign setup = psel && !penable;

    // One wait-free access phase: read data is captured in setup, so it comes from a flop.
    assign pready = psel && penable;
    assign pslverr = pready && !hit_r;
    assign prdata = rdata_r;

    // Writes land only at the completing edge and only with byte lane 0 enabled.
    assign lane0 = pstrb[0];
    assign wr_go = pready && pwrite && hit_r && lane0;
    assign wbyte = pwdata[7:0];
    assign wr_clip_l = wr_go && (idx == RLC_CLIP_L_IDX);
    assign wr_clip_r = wr_go && (idx == RLC_CLIP_R_IDX);
    assign mode = rlc_mode_type'(ctrl_r[RLC_CTRL_MODE_MSB:0]);

    // Read data and address hit are sampled in the setup cycle of every transfer.
    always_comb begin
        rdata_nxt = rdata_r;
        hit_nxt = hit_r;
        if (setup) begin
            hit_nxt = addr_ok;
            rdata_nxt = 32'h0000_0000;
            if (!pwrite && addr_ok) begin
                unique case (idx)
                    RLC_THR_SLOPE_IDX: rdata_nxt[7:0] = {thr_r, 1'b0, slope_r};
                    RLC_KNEE_IDX: rdata_nxt[7:0] = knee_r;
                    RLC_CLIP_L_IDX: rdata_nxt[7:0] = clip_l_code;
                    RLC_CLIP_R_IDX: rdata_nxt[7:0] = clip_r_code;
                    RLC_CTRL_IDX: rdata_nxt[3:0] = ctrl_r;
                    default: rdata_nxt[7:0] = {eff_thr_r, mute_r, active_r, below_r};
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
            hit_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
        end
    end

    // Control registers take the written byte on the completing edge.
    always_comb begin
        thr_nxt = thr_r;
        slope_nxt = slope_r;
        knee_nxt = knee_r;
        ctrl_nxt = ctrl_r;
        if (wr_go && idx == RLC_THR_SLOPE_IDX) begin
            thr_nxt = wbyte[RLC_THR_MSB:RLC_THR_LSB];
            // Slope field; write to bit 2 is dropped.
            slope_nxt = wbyte[RLC_SLOPE_MSB:RLC_SLOPE_LSB];
        end
        if (wr_go && idx == RLC_KNEE_IDX) begin
            knee_nxt = wbyte;
        end
        if (wr_go && idx == RLC_CTRL_IDX) begin
            ctrl_nxt = wbyte[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_r <= RLC_THR_SLOPE_RST[RLC_THR_MSB:RLC_THR_LSB];
            slope_r <= RLC_THR_SLOPE_RST[RLC_SLOPE_MSB:RLC_SLOPE_LSB];
            knee_r <= RLC_KNEE_RST;
            ctrl_r <= RLC_CTRL_RST[3:0];
        end else begin
            thr_r <= thr_nxt;
            slope_r <= slope_nxt;
            knee_r <= knee_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    rlc_clip u_clip_left (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_clip_l),
        .wr_data(wbyte),
        .clip_code(clip_l_code),
        .clip_level(left_clip_level)
    );

    // Right clip level, independent of the left one.
    rlc_clip u_clip_right (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_clip_r),
        .wr_data(wbyte),
        .clip_code(clip_r_code),
        .clip_level(right_clip_level)
    );

    // Raw code comparison against the battery converter output.
    assign deficit = knee_r - battery_code;
    // Slope ratio multiplies the battery shortfall, slope_r plus one code steps per LSB.
    assign reduction = 10'(deficit) * 10'({1'b0, slope_r} + 3'h1);
    assign deeper = 11'(thr_r) + 11'(reduction);

    // Threshold tracking, link and mode. A lower voltage is a larger code, so tracking
    // raises the code and saturates at 2 V rather than wrapping back to 16 V.
    always_comb begin
        below_nxt = battery_code < knee_r;
        eff_thr_nxt = thr_r;
        // Tracking lowers the threshold below the knee.
        if (ctrl_r[RLC_CTRL_TRACK_BIT] && below_nxt) begin
            eff_thr_nxt = (deeper > 11'(RLC_THR_MAX)) ? RLC_THR_MAX : deeper[4:0];
        end
        // Linked channels follow the left limiter.
        if (ctrl_r[RLC_CTRL_LINK_BIT]) begin
            eff_thr_nxt = left_threshold_code;
        end
        unique case (mode)
            RLC_MODE_OFF: begin
                active_nxt = 1'b0;
                mute_nxt = 1'b0;
            end
            RLC_MODE_ON: begin
                active_nxt = 1'b1;
                mute_nxt = 1'b0;
            end
            RLC_MODE_MUTE_LOW: begin
                active_nxt = 1'b0;
                mute_nxt = below_nxt;
            end
            RLC_MODE_ON_LOW: begin
                active_nxt = below_nxt;
                mute_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_thr_r <= RLC_THR_SLOPE_RST[RLC_THR_MSB:RLC_THR_LSB];
            active_r <= 1'b0;
            mute_r <= 1'b0;
            below_r <= 1'b0;
        end else begin
            eff_thr_r <= eff_thr_nxt;
            active_r <= active_nxt;
            mute_r <= mute_nxt;
            below_r <= below_nxt;
        end
    end

    assign right_threshold_code = eff_thr_r;
    assign right_limiter_active = active_r;
    assign right_mute = mute_r;
    assign right_use_left_limiter = ctrl_r[RLC_CTRL_LINK_BIT];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // The setup cycle of a read of the threshold register; the access with the data is s_access_done.
    sequence s_thr_read;
        setup && !pwrite && paddr == {RLC_THR_SLOPE_IDX, 2'h0};
    endsequence

    sequence s_access_done;
        pready && !pslverr;
    endsequence

    a_thr_written: assert property (
        wr_go && idx == RLC_THR_SLOPE_IDX |=> thr_r == $past(pwdata[7:3]))
        else $error("threshold field not written");

    a_slope_written: assert property (
        wr_go && idx == RLC_THR_SLOPE_IDX |=> slope_r == $past(pwdata[1:0]))
        else $error("slope field not written");

    a_knee_written: assert property (
        wr_go && idx == RLC_KNEE_IDX |=> knee_r == $past(pwdata[7:0]))
        else $error("knee field not written");

    a_left_clip_kept: assert property (
        !wr_clip_l |=> $stable(clip_l_code))
        else $error("left clip code changed without a write");

    a_right_clip_alone: assert property (
        wr_clip_l && !wr_clip_r |=> $stable(clip_r_code))
        else $error("left clip write disturbed right clip");

    a_reserved_zero: assert property (
        s_thr_read ##1 s_access_done |-> prdata[2] == 1'b0 && prdata[7:3] == thr_r)
        else $error("threshold read wrong or reserved bit set");

    a_track_lowers: assert property (
        ctrl_r[RLC_CTRL_TRACK_BIT] && !ctrl_r[RLC_CTRL_LINK_BIT] && battery_code < knee_r
        |=> right_threshold_code >= $past(thr_r))
        else $error("tracking raised the threshold voltage");

    a_fixed_thr: assert property (
        !ctrl_r[RLC_CTRL_LINK_BIT] && !(ctrl_r[RLC_CTRL_TRACK_BIT] && battery_code < knee_r)
        |=> right_threshold_code == $past(thr_r))
        else $error("fixed threshold not applied");

    a_link_follows: assert property (
        ctrl_r[RLC_CTRL_LINK_BIT] |=> right_threshold_code == $past(left_threshold_code))
        else $error("linked channel ignores left threshold");

    a_mode_mute: assert property (
        mode == RLC_MODE_MUTE_LOW && battery_code < knee_r |=> right_mute && !right_limiter_active)
        else $error("mute when low not applied");

    a_mode_off: assert property (
        mode == RLC_MODE_OFF |=> !right_mute && !right_limiter_active)
        else $error("limiter not off");

endmodule : rlc_top

// [testbench/tb_right_limiter_and_dac_clip_cfg.sv]
// Self-checking bench for the right limiter and DAC clip register bank.
`timescale 1ns/100ps
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin errors++; \
    $display("Error at %0t ns: got %h expected %h", $time, (act), (exp)); end end
module tb_right_limiter_and_dac_clip_cfg import rlc_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [RLC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] battery_code;
    logic [4:0] left_threshold_code, right_threshold_code;
    logic right_limiter_active, right_mute, right_use_left_limiter;
    logic [8:0] left_clip_level, right_clip_level;
    logic [7:0] clip_codes [4] = '{8'h00, 8'h01, 8'h7f, 8'hfe};
    int errors, n_tests;
    // Byte addresses are four times the register index.
    localparam logic [9:0] A_THR = {RLC_THR_SLOPE_IDX, 2'b00};
    localparam logic [9:0] A_KNEE = {RLC_KNEE_IDX, 2'b00};
    localparam logic [9:0] A_CL = {RLC_CLIP_L_IDX, 2'b00};
    localparam logic [9:0] A_CR = {RLC_CLIP_R_IDX, 2'b00};
    localparam logic [9:0] A_CTRL = {RLC_CTRL_IDX, 2'b00};
    localparam logic [9:0] A_STAT = {RLC_STAT_IDX, 2'b00};

    rlc_top rlc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .battery_code(battery_code),
        .left_threshold_code(left_threshold_code), .right_threshold_code(right_threshold_code),
        .right_limiter_active(right_limiter_active), .right_mute(right_mute),
        .right_use_left_limiter(right_use_left_limiter), .left_clip_level(left_clip_level),
        .right_clip_level(right_clip_level));

    // The clock toggles every 20 ns, for a period of 40 ns.
    always #20 pclk = ~pclk;

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            errors++;
            stop_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr_reg

    // A read must answer without error and with the upper lanes zero.
    task automatic chk_rd(input logic [9:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 4'hf);
        `CHK({err, rd}, {1'b0, 24'h0, exp})
    endtask : chk_rd

    // Outputs follow a register or input change one edge after it is taken.
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task automatic set_bat(input logic [7:0] v);
        @(posedge pclk);
        battery_code <= v;
        settle();
    endtask : set_bat

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        battery_code = 8'hff;
        left_threshold_code = 5'h13;
        errors = 0;
        n_tests = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk_rd(A_THR, 8'h51);
        chk_rd(A_KNEE, 8'h22);
        chk_rd(A_CL, 8'hff);
        chk_rd(A_CR, 8'hff);
        chk_rd(A_CTRL, 8'h08);
        `CHK({right_use_left_limiter, right_limiter_active, right_mute}, 3'b100)
        `CHK(left_clip_level, 9'h100)
        `CHK(right_clip_level, 9'h100)
        wr_reg(A_THR, 8'hff);
        chk_rd(A_THR, 8'hfb);
        wr_reg(A_KNEE, 8'h5a);
        chk_rd(A_KNEE, 8'h5a);
        // clip numerators, both channels written apart.
        foreach (clip_codes[k]) begin
            wr_reg(A_CL, clip_codes[k]);
            wr_reg(A_CR, ~clip_codes[k]);
            settle();
            `CHK(left_clip_level, {1'b0, clip_codes[k]} + 9'h1)
            `CHK(right_clip_level, {1'b0, ~clip_codes[k]} + 9'h1)
            chk_rd(A_CL, clip_codes[k]);
            chk_rd(A_CR, ~clip_codes[k]);
        end
        // Refused accesses leave the registers alone.
        apb(1'b0, 10'h058, 8'h00, 4'hf);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 10'h055, 8'h44, 4'hf);
        `CHK(err, 1'b1)
        // A write without lane 0 is dropped quietly, so the last loop value must remain.
        apb(1'b1, A_CR, 8'h33, 4'h0);
        `CHK(err, 1'b0)
        chk_rd(A_CR, ~clip_codes[3]);
        wr_reg(A_KNEE, 8'h22);
        wr_reg(A_CTRL, 8'h01);
        wr_reg(A_THR, 8'h28);
        set_bat(8'h20);
        `CHK({right_threshold_code, right_limiter_active}, {5'h05, 1'b1})
        `CHK(right_use_left_limiter, 1'b0)
        wr_reg(A_CTRL, 8'h05);
        for (int s = 0; s < 4; s++) begin
            wr_reg(A_THR, 8'h28 | 8'(s));
            settle();
            `CHK(right_threshold_code, 5'(5 + 2 * (s + 1)))
        end
        set_bat(8'h00);
        `CHK(right_threshold_code, RLC_THR_MAX)
        set_bat(8'h22);
        `CHK(right_threshold_code, 5'h05)
        wr_reg(A_CTRL, 8'h02);
        set_bat(8'h21);
        `CHK(right_mute, 1'b1)
        set_bat(8'h22);
        `CHK(right_mute, 1'b0)
        wr_reg(A_CTRL, 8'h03);
        set_bat(8'h21);
        `CHK(right_limiter_active, 1'b1)
        chk_rd(A_STAT, 8'h2b);
        set_bat(8'h22);
        `CHK(right_limiter_active, 1'b0)
        wr_reg(A_CTRL, 8'h00);
        set_bat(8'h21);
        `CHK({right_limiter_active, right_mute}, 2'b00)
        // linked channels follow the left threshold.
        wr_reg(A_CTRL, 8'h09);
        settle();
        `CHK({right_threshold_code, right_use_left_limiter}, {5'h13, 1'b1})
        @(posedge pclk);
        left_threshold_code <= 5'h07;
        settle();
        `CHK(right_threshold_code, 5'h07)
        stop_test();
    end
endmodule : tb_right_limiter_and_dac_clip_cfg
